// >>> rtl/acpc_top.sv
// converter control registers, sequencer and port decode behind apb
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module acpc_top
    import acpc_pkg::*;
#(
    parameter bit         PIN28   = 1'b0,
    parameter logic [6:0] FRC_DIV = 7'h20
) (
    input  wire logic        MCLK,
    input  wire logic        RESETN,
    input  wire logic        CE,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        PORT_ANALOG_STRAP,
    input  wire logic        CONV_DONE,
    input  wire logic [9:0]  CONV_RESULT,
    output logic      [3:0]  CH_SEL,
    output logic             CH_VALID,
    output logic             SAMPLE,
    output logic             CONV_START,
    output logic             NEG_REF_SEL,
    output logic             POS_REF_SEL,
    output logic      [12:0] ANALOG_CFG,
    output logic             IRQ
);
    // register state
    logic        en_r, en_nxt;
    logic        go_r, go_nxt;
    logic [3:0]  chs_r, chs_nxt;
    logic        nref_r, nref_nxt;
    logic        pref_r, pref_nxt;
    logic [3:0]  pcfg_r, pcfg_nxt;
    logic [7:0]  ctrl2_r, ctrl2_nxt;
    logic [7:0]  resh_r, resh_nxt;
    logic [7:0]  resl_r, resl_nxt;
    logic        istat_r, istat_nxt;
    logic        imask_r, imask_nxt;
    acpc_state_t state_r, state_nxt;
    logic [4:0]  cnt_r, cnt_nxt;
    logic        start_r, start_nxt;
    logic [1:0]  init_cnt_r, init_cnt_nxt;
    logic        init_done_r, init_done_nxt;
    // bus state
    logic [31:0] prdata_r, prdata_nxt;
    logic        pready_r, pready_nxt;
    logic        pslverr_r, pslverr_nxt;
    // registered outputs
    logic [3:0]  chsel_r;
    logic        chvalid_r;
    logic        sample_r;
    logic        nref_o_r;
    logic        pref_o_r;
    logic [12:0] acfg_r;
    logic        irq_r;
    // strap synchroniser
    logic        strap_s1_r;
    logic        strap_s2_r;
    // decode
    logic        wr;
    logic        mapped;
    logic        go_set;
    logic        tick;
    logic        chs_ok;
    logic [12:0] acfg_calc;
    logic [4:0]  acq_len;
    logic [2:0]  acqt;
    logic [7:0]  rd_byte;

    acpc_tad #(
        .FRC_DIV (FRC_DIV)
    ) u_tad (
        .clk   (MCLK),
        .rst_n (RESETN),
        .ce    (CE),
        .run   (state_r != ACPC_IDLE),
        .sel   (ctrl2_r[ACPC_ADCS_LSB +: 3]),
        .tick  (tick)
    );

    // write strobe only at the completing edge of the access phase
    assign wr     = PSEL & PENABLE & pready_r & PWRITE;
    assign mapped = (PADDR <= ACPC_OFF_IMASK) && (PADDR[1:0] == 2'b00);
    assign acqt   = ctrl2_r[ACPC_ACQT_LSB +: 3];
    assign acq_len = ACPC_ACQ_TAD[acqt];
    // start bit only takes while already enabled
    assign go_set = wr && (PADDR == ACPC_OFF_CTRL0) && PWDATA[ACPC_GO_BIT]
                    && en_r && !go_r;

    // implemented channel check, gap only on the small package
    always_comb begin
        chs_ok = (chs_r <= ACPC_CHS_LAST);
        if (PIN28 && chs_r >= ACPC_GAP_LO && chs_r <= ACPC_GAP_HI) begin
            chs_ok = 1'b0;
        end
    end

    // per-input analog/digital decode
    genvar gi;
    generate
        for (gi = 0; gi < 13; gi++) begin : g_cfg
            always_comb begin
                if (pcfg_r <= ACPC_PCFG_AMAX) begin
                    acfg_calc[gi] = 1'b1;
                end else begin
                    acfg_calc[gi] = (5'(gi) < (ACPC_PCFG_BASE - {1'b0, pcfg_r}));
                end
            end
        end
    endgenerate

    // read mux, unused bits read zero
    always_comb begin
        rd_byte = 8'h00;
        unique case (PADDR)
            ACPC_OFF_CTRL0: rd_byte = {2'b00, chs_r, go_r, en_r};
            ACPC_OFF_CTRL1: rd_byte = {2'b00, nref_r, pref_r, pcfg_r};
            ACPC_OFF_CTRL2: rd_byte = {ctrl2_r[7], 1'b0, ctrl2_r[5:0]};
            ACPC_OFF_RESH:  rd_byte = resh_r;
            ACPC_OFF_RESL:  rd_byte = resl_r;
            ACPC_OFF_ISTAT: rd_byte = {7'h00, istat_r};
            ACPC_OFF_IMASK: rd_byte = {7'h00, imask_r};
            default:        rd_byte = 8'h00;
        endcase
    end

    // apb: answer prepared in setup, ready for the first access edge
    always_comb begin
        pready_nxt  = PSEL & ~PENABLE;
        prdata_nxt  = prdata_r;
        pslverr_nxt = 1'b0;
        if (PSEL && !PENABLE) begin
            prdata_nxt  = {24'h000000, rd_byte};
            pslverr_nxt = !mapped;
        end
    end

    // registers and sequencer
    always_comb begin
        en_nxt        = en_r;
        go_nxt        = go_r;
        chs_nxt       = chs_r;
        nref_nxt      = nref_r;
        pref_nxt      = pref_r;
        pcfg_nxt      = pcfg_r;
        ctrl2_nxt     = ctrl2_r;
        resh_nxt      = resh_r;
        resl_nxt      = resl_r;
        istat_nxt     = istat_r;
        imask_nxt     = imask_r;
        state_nxt     = state_r;
        cnt_nxt       = cnt_r;
        start_nxt     = 1'b0;
        init_cnt_nxt  = init_cnt_r;
        init_done_nxt = init_done_r;
        // software writes; top bits of control zero and one dropped
        if (wr) begin
            unique case (PADDR)
                ACPC_OFF_CTRL0: begin
                    chs_nxt = PWDATA[ACPC_CHS_LSB +: 4];
                    en_nxt  = PWDATA[ACPC_EN_BIT];
                end
                ACPC_OFF_CTRL1: begin
                    nref_nxt = PWDATA[ACPC_NREF_BIT];
                    pref_nxt = PWDATA[ACPC_PREF_BIT];
                    pcfg_nxt = PWDATA[ACPC_PCFG_LSB +: 4];
                end
                ACPC_OFF_CTRL2: ctrl2_nxt = {PWDATA[7], 1'b0, PWDATA[5:0]};
                ACPC_OFF_ISTAT: istat_nxt = istat_r & ~PWDATA[ACPC_DONE_BIT];
                ACPC_OFF_IMASK: imask_nxt = PWDATA[ACPC_DONE_BIT];
                default: ;
            endcase
        end
        if (go_set) begin
            go_nxt = 1'b1;
        end
        // sequencer
        unique case (state_r)
            ACPC_IDLE: begin
                if (go_set) begin
                    cnt_nxt = 5'h00;
                    if (acq_len == 5'h00) begin
                        state_nxt = ACPC_CONV;
                        start_nxt = 1'b1;
                    end else begin
                        state_nxt = ACPC_ACQ;
                    end
                end
            end
            ACPC_ACQ: begin
                if (tick) begin
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r + 5'h01 >= acq_len) begin
                        state_nxt = ACPC_CONV;
                        start_nxt = 1'b1;
                    end
                end
            end
            ACPC_CONV: begin
                if (CONV_DONE) begin
                    // right or left justification chosen at load
                    if (ctrl2_r[ACPC_JUST_BIT]) begin
                        resh_nxt = {6'h00, CONV_RESULT[9:8]};
                        resl_nxt = CONV_RESULT[7:0];
                    end else begin
                        resh_nxt = CONV_RESULT[9:2];
                        resl_nxt = {CONV_RESULT[1:0], 6'h00};
                    end
                    go_nxt    = 1'b0;
                    istat_nxt = 1'b1;
                    state_nxt = ACPC_HOLD;
                    cnt_nxt   = 5'h00;
                end
            end
            ACPC_HOLD: begin
                // settle gap before a new acquisition may start
                if (tick) begin
                    cnt_nxt = cnt_r + 5'h01;
                    if (cnt_r + 5'h01 >= ACPC_POST_TAD) begin
                        cnt_nxt = 5'h00;
                        if (!go_r) begin
                            state_nxt = ACPC_IDLE;
                        end else if (acq_len == 5'h00) begin
                            state_nxt = ACPC_CONV;
                            start_nxt = 1'b1;
                        end else begin
                            state_nxt = ACPC_ACQ;
                        end
                    end
                end
            end
        endcase
        // disabling aborts whatever is running
        if (!en_nxt) begin
            go_nxt    = 1'b0;
            state_nxt = ACPC_IDLE;
            start_nxt = 1'b0;
        end
        // strap sampled once the synchroniser has filled
        if (!init_done_r) begin
            if (init_cnt_r == ACPC_SETTLE) begin
                pcfg_nxt = strap_s2_r ? ACPC_PCFG_ST1 : ACPC_PCFG_ST0;
                init_done_nxt = 1'b1;
            end else begin
                init_cnt_nxt = init_cnt_r + 2'h1;
            end
        end
    end

    // registers, sequencer and bus state; reset aborts any conversion
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            en_r        <= 1'b0;
            go_r        <= 1'b0;
            chs_r       <= ACPC_CHS_RST;
            nref_r      <= ACPC_VCFG_RST;
            pref_r      <= ACPC_VCFG_RST;
            pcfg_r      <= ACPC_PCFG_ST1;
            ctrl2_r     <= ACPC_CTRL2_RST;
            resh_r      <= 8'h00;
            resl_r      <= 8'h00;
            istat_r     <= 1'b0;
            imask_r     <= 1'b0;
            state_r     <= ACPC_IDLE;
            cnt_r       <= 5'h00;
            start_r     <= 1'b0;
            init_cnt_r  <= 2'h0;
            init_done_r <= 1'b0;
            prdata_r    <= 32'h00000000;
            pready_r    <= 1'b0;
            pslverr_r   <= 1'b0;
        end else if (CE) begin
            en_r        <= en_nxt;
            go_r        <= go_nxt;
            chs_r       <= chs_nxt;
            nref_r      <= nref_nxt;
            pref_r      <= pref_nxt;
            pcfg_r      <= pcfg_nxt;
            ctrl2_r     <= ctrl2_nxt;
            resh_r      <= resh_nxt;
            resl_r      <= resl_nxt;
            istat_r     <= istat_nxt;
            imask_r     <= imask_nxt;
            state_r     <= state_nxt;
            cnt_r       <= cnt_nxt;
            start_r     <= start_nxt;
            init_cnt_r  <= init_cnt_nxt;
            init_done_r <= init_done_nxt;
            prdata_r    <= prdata_nxt;
            pready_r    <= pready_nxt;
            pslverr_r   <= pslverr_nxt;
        end
    end

    // strap pin is asynchronous, two stages before use
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            strap_s1_r <= 1'b0;
            strap_s2_r <= 1'b0;
        end else if (CE) begin
            strap_s1_r <= PORT_ANALOG_STRAP;
            strap_s2_r <= strap_s1_r;
        end
    end

    // outputs to the analog side and the interrupt, one register stage
    always_ff @(posedge MCLK or negedge RESETN) begin
        if (!RESETN) begin
            chsel_r   <= 4'h0;
            chvalid_r <= 1'b0;
            sample_r  <= 1'b0;
            nref_o_r  <= 1'b0;
            pref_o_r  <= 1'b0;
            acfg_r    <= 13'h0000;
            irq_r     <= 1'b0;
        end else if (CE) begin
            chsel_r   <= chs_r;
            chvalid_r <= chs_ok;
            sample_r  <= en_r && (state_r == ACPC_IDLE || state_r == ACPC_ACQ);
            nref_o_r  <= nref_r;
            pref_o_r  <= pref_r;
            acfg_r    <= acfg_calc;
            irq_r     <= istat_r & imask_r;
        end
    end

    assign PRDATA      = prdata_r;
    assign PREADY      = pready_r;
    assign PSLVERR     = pslverr_r;
    assign CH_SEL      = chsel_r;
    assign CH_VALID    = chvalid_r;
    assign SAMPLE      = sample_r;
    assign CONV_START  = start_r;
    assign NEG_REF_SEL = nref_o_r;
    assign POS_REF_SEL = pref_o_r;
    assign ANALOG_CFG  = acfg_r;
    assign IRQ         = irq_r;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESETN);

    a_sel_follow: assert property (CE |=> CH_SEL == $past(chs_r))
        else $error("selector output does not follow field");
    a_chan_valid: assert property (CE && chs_r > ACPC_CHS_LAST |=> !CH_VALID)
        else $error("unimplemented selector code marked valid");
    a_gap_chan: assert property (CE && chs_r >= ACPC_GAP_LO
                                 && chs_r <= ACPC_GAP_HI |=> CH_VALID == !PIN28)
        else $error("gap channel validity does not match package");
    a_busy_go: assert property (state_r == ACPC_ACQ || state_r == ACPC_CONV |-> go_r)
        else $error("busy without status bit");
    a_off_idle: assert property (!en_r |-> state_r == ACPC_IDLE && !go_r)
        else $error("disabled converter not idle");
    a_top_zero: assert property (CE && PSEL && !PENABLE && PADDR <= ACPC_OFF_CTRL1
                                 |=> PRDATA[7:6] == 2'b00)
        else $error("unimplemented bits read nonzero");
    a_refs: assert property (CE |=> NEG_REF_SEL == $past(nref_r)
                             && POS_REF_SEL == $past(pref_r))
        else $error("reference selects not driven");
    a_cfg_ends: assert property (CE && pcfg_r <= ACPC_PCFG_AMAX |=> ANALOG_CFG == 13'h1FFF)
        else $error("low port codes not all analog");
    a_cfg_dig: assert property (CE && pcfg_r == 4'hF |=> ANALOG_CFG == 13'h0000)
        else $error("top port code not all digital");
    a_strap: assert property (CE && !init_done_r && init_cnt_r == ACPC_SETTLE
                              |=> pcfg_r == ($past(strap_s2_r) ? 4'h0 : 4'h7))
        else $error("strap value not loaded");
    a_done_load: assert property (CE && state_r == ACPC_CONV && CONV_DONE && en_nxt
                                  |=> !go_r && istat_r && state_r == ACPC_HOLD)
        else $error("conversion end effects missing");
    a_just_right: assert property (CE && state_r == ACPC_CONV && CONV_DONE
                                   && ctrl2_r[ACPC_JUST_BIT] |=> resh_r[7:2] == 6'h00)
        else $error("right justified high byte not clear");
    a_acq_zero: assert property (CE && state_r == ACPC_IDLE && go_set && acq_len == 5'h00
                                 && en_nxt |=> CONV_START && state_r == ACPC_CONV)
        else $error("manual acquisition did not start at once");
    a_irq_lvl: assert property (CE |=> IRQ == $past(istat_r & imask_r))
        else $error("interrupt level wrong");

    c_done: cover property (state_r == ACPC_CONV && CONV_DONE);
    c_timed: cover property (state_r == ACPC_ACQ ##[1:400] CONV_START);
    c_float: cover property (CONV_START && !chs_ok);
    c_irq: cover property (IRQ);
endmodule // acpc_top
`default_nettype wire

// >>> rtl/acpc_pkg.sv
// constants, types and register map of the converter control block
// Overview of operation
// - selector bits 5..2 of control zero route inputs 0..12 to the converter
// - selector codes 13..15 pick no input; conversion returns a floating reading
// - 28-pin variant treats selector codes 5..7 as unimplemented
// - 10 inputs on 28-pin, 13 on 40/44-pin; 10-bit result
// - while enabled, bit 1 of control zero reads 1 while converting
// - bit 0 of control zero enables or disables the converter
// - bits 7..6 of control zero and one ignore writes, read zero
// - control one bit 5 selects negative reference: input 2 pin or ground
// - control one bit 4 selects positive reference: input 3 pin or supply
// - port code 0..2 all analog; each step above turns next top input digital
// - reset loads port code 0000 with strap high, 0111 with strap low
// - conversion end loads result pair, clears start bit, sets done flag
// - reset returns all registers to reset state, aborting any conversion
// - control two bit 7: 1 right-justified result, 0 left-justified
// - acquisition code 000 starts conversion at once on start bit
package acpc_pkg;
    // register byte offsets
    localparam logic [7:0] ACPC_OFF_CTRL0 = 8'h00;
    localparam logic [7:0] ACPC_OFF_CTRL1 = 8'h04;
    localparam logic [7:0] ACPC_OFF_CTRL2 = 8'h08;
    localparam logic [7:0] ACPC_OFF_RESH  = 8'h0C;
    localparam logic [7:0] ACPC_OFF_RESL  = 8'h10;
    localparam logic [7:0] ACPC_OFF_ISTAT = 8'h14;
    localparam logic [7:0] ACPC_OFF_IMASK = 8'h18;
    // field positions
    localparam int ACPC_EN_BIT   = 0;
    localparam int ACPC_GO_BIT   = 1;
    localparam int ACPC_CHS_LSB  = 2;
    localparam int ACPC_PREF_BIT = 4;
    localparam int ACPC_NREF_BIT = 5;
    localparam int ACPC_PCFG_LSB = 0;
    localparam int ACPC_JUST_BIT = 7;
    localparam int ACPC_ACQT_LSB = 3;
    localparam int ACPC_ADCS_LSB = 0;
    localparam int ACPC_DONE_BIT = 0;
    // reset values
    localparam logic [3:0] ACPC_CHS_RST   = 4'h0;
    localparam logic [7:0] ACPC_CTRL2_RST = 8'h00;
    localparam logic [3:0] ACPC_PCFG_ST1  = 4'h0;
    localparam logic [3:0] ACPC_PCFG_ST0  = 4'h7;
    localparam logic       ACPC_VCFG_RST  = 1'b0;
    // channel and port decode
    localparam logic [3:0] ACPC_CHS_LAST  = 4'hC;
    localparam logic [3:0] ACPC_GAP_LO    = 4'h5;
    localparam logic [3:0] ACPC_GAP_HI    = 4'h7;
    localparam logic [3:0] ACPC_PCFG_AMAX = 4'h2;
    localparam logic [4:0] ACPC_PCFG_BASE = 5'h0F;
    localparam logic [4:0] ACPC_NUM_IN    = 5'h0D;
    // timing counts in converter clock periods; settle count in clock cycles
    localparam logic [4:0] ACPC_ACQ_TAD [0:7] = '{5'h00, 5'h02, 5'h04, 5'h06,
                                                 5'h08, 5'h0C, 5'h10, 5'h14};
    localparam logic [4:0] ACPC_POST_TAD = 5'h03;
    localparam logic [1:0] ACPC_SETTLE   = 2'h2;
    typedef enum logic [1:0] {ACPC_IDLE, ACPC_ACQ, ACPC_CONV, ACPC_HOLD} acpc_state_t;
endpackage

// >>> rtl/acpc_tad.sv
// converter clock period tick generator
`timescale 1ns/100ps
`default_nettype none
module acpc_tad #(
    parameter logic [6:0] FRC_DIV = 7'h20
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       run,
    input  wire logic [2:0] sel,
    output logic            tick
);
    logic [6:0] div;
    logic [6:0] cnt_r;
    logic [6:0] cnt_nxt;
    logic       tick_r;
    logic       tick_nxt;

    // divider per clock select code
    always_comb begin
        unique case (sel)
            3'h0: div = 7'h02;
            3'h1: div = 7'h08;
            3'h2: div = 7'h20;
            3'h4: div = 7'h04;
            3'h5: div = 7'h10;
            3'h6: div = 7'h40;
            default: div = FRC_DIV; // rc source stands in as a fixed divider
        endcase
    end

    // restart from zero whenever idle so acquisition is deterministic
    always_comb begin
        cnt_nxt  = 7'h00;
        tick_nxt = 1'b0;
        if (run) begin
            if (cnt_r == div - 7'h01) begin
                tick_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 7'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r  <= 7'h00;
            tick_r <= 1'b0;
        end else if (ce) begin
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r & run;
endmodule // acpc_tad
`default_nettype wire

// >>> verif/acpc_core_model.sv
// behavioural model of the converter core
`timescale 1ns/100ps
`default_nettype none
module acpc_core_model #(
    parameter logic [9:0] RES = 10'h2A5
) (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       conv_start,
    input  wire logic [7:0] dly,
    output logic            conv_done,
    output logic      [9:0] conv_result
);
    logic       busy_r;
    logic [7:0] cnt_r;
    // count dly cycles after start, then one done pulse
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_r    <= 1'b0;
            cnt_r     <= 8'h00;
            conv_done <= 1'b0;
        end else begin
            conv_done <= 1'b0;
            if (conv_start) begin
                busy_r <= 1'b1;
                cnt_r  <= dly;
            end else if (busy_r && cnt_r == 8'h00) begin
                busy_r    <= 1'b0;
                conv_done <= 1'b1;
            end else if (busy_r) begin
                cnt_r <= cnt_r - 8'h01;
            end
        end
    end
    // 10-bit result only valid with done; inverted otherwise to expose late sampling
    assign conv_result = conv_done ? RES : ~RES;
endmodule // acpc_core_model
`default_nettype wire

// >>> verif/tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import acpc_pkg::*;
    logic        MCLK, RESETN, psel, penable, pwrite, strap, done, slverr, slv_seen;
    logic        ch_valid, sample, conv_start, nref, pref, irq, pready;
    logic [7:0]  paddr, dly;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0]  result;
    logic [3:0]  ch_sel;
    logic [12:0] acfg;
    int          errors, comparisons;
    // ctrl1 write value beside its read-back value
    logic [15:0] rows [0:4] = '{16'hFF3F, 16'h2323, 16'h1212, 16'h0B0B, 16'h1E1E};
    acpc_top dut (.MCLK(MCLK), .RESETN(RESETN), .CE(1'b1), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(slverr), .PORT_ANALOG_STRAP(strap), .CONV_DONE(done), .CONV_RESULT(result),
        .CH_SEL(ch_sel), .CH_VALID(ch_valid), .SAMPLE(sample), .CONV_START(conv_start),
        .NEG_REF_SEL(nref), .POS_REF_SEL(pref), .ANALOG_CFG(acfg), .IRQ(irq));
    acpc_core_model core (.clk(MCLK), .rst_n(RESETN), .conv_start(conv_start), .dly(dly),
        .conv_done(done), .conv_result(result));
    // 50 MHz clock
    initial begin
        MCLK = 1'b0;
        forever #10 MCLK = ~MCLK;
    end
    function automatic logic [12:0] cfg_exp(input logic [3:0] c);
        return (c <= 4'h2) ? 13'h1FFF : 13'h1FFF >> (c - 4'h2);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; request held until pready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge MCLK);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge MCLK);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do begin @(posedge MCLK); end while (pready !== 1'b1);
        rd = prdata;
        slv_seen = slverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic reset_dut;
        RESETN <= 1'b0;
        repeat (4) @(posedge MCLK);
        chk(32'({irq, pready, acfg}), 32'h0);
        RESETN <= 1'b1;
        repeat (4) @(posedge MCLK);
    endtask
    // start on input 3 and poll the busy bit until it drops
    task automatic conv(input logic [7:0] d);
        int n = 0;
        dly <= d;
        apb(1'b1, ACPC_OFF_CTRL0, 32'h0F);
        apb(1'b0, ACPC_OFF_CTRL0, 32'h0);
        if (d > 8'h10) chk(rd, 32'h0F);
        do begin apb(1'b0, ACPC_OFF_CTRL0, 32'h0); n++; end while (rd[1] !== 1'b0 && n < 60);
        chk(rd, 32'h0D);
    endtask
    task automatic print_verdict;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // hang guard, far beyond the few hundred cycles the tests take
    initial begin
        repeat (20000) @(posedge MCLK);
        errors++;
        print_verdict();
    end
    // main sequence: reset defaults, table loop, selector sweep, then hand-written cases
    initial begin
        errors = 0;
        comparisons = 0;
        {psel, penable, pwrite, paddr, pwdata, strap, dly} = '0;
        reset_dut();
        apb(1'b0, ACPC_OFF_CTRL1, 32'h0);
        chk(rd, 32'h07);
        chk(32'(acfg), 32'h00FF);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, ACPC_OFF_CTRL1, {24'h0, rows[i][15:8]});
            apb(1'b0, ACPC_OFF_CTRL1, 32'h0);
            chk(rd, {24'h0, rows[i][7:0]});
            chk(32'({nref, pref}), 32'(rows[i][5:4]));
            chk(32'(acfg), 32'(cfg_exp(rows[i][3:0])));
        end
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, ACPC_OFF_CTRL0, 32'(c << 2) | 32'hC0);
            apb(1'b0, ACPC_OFF_CTRL0, 32'h0);
            chk(rd, 32'(c << 2));
            chk(32'(ch_sel), 32'(c));
            chk(32'(ch_valid), 32'(c <= 12));
        end
        apb(1'b1, ACPC_OFF_CTRL0, 32'h02);
        apb(1'b0, ACPC_OFF_CTRL0, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 8'h1C, 32'hFF);
        chk(32'(slv_seen), 32'h1);
        apb(1'b0, 8'h02, 32'h0);
        chk(rd | 32'(!slv_seen), 32'h0);
        // right-justified, 20-tick timed acquisition, interrupt unmasked
        apb(1'b1, ACPC_OFF_IMASK, 32'h1);
        apb(1'b1, ACPC_OFF_CTRL2, 32'hB8);
        apb(1'b1, ACPC_OFF_CTRL0, 32'h0D);
        // enable lands at the write edge, sample flop follows one edge later
        repeat (2) @(posedge MCLK);
        chk(32'(sample), 32'h1);
        conv(8'h28);
        chk(32'(irq), 32'h1);
        apb(1'b0, ACPC_OFF_RESH, 32'h0);
        chk(rd, 32'h02);
        apb(1'b0, ACPC_OFF_RESL, 32'h0);
        chk(rd, 32'hA5);
        apb(1'b1, ACPC_OFF_ISTAT, 32'h1);
        apb(1'b0, ACPC_OFF_ISTAT, 32'h0);
        chk(rd | 32'(irq), 32'h0);
        // left-justified, prompt core, interrupt masked then unmasked
        apb(1'b1, ACPC_OFF_IMASK, 32'h0);
        apb(1'b1, ACPC_OFF_CTRL2, 32'h00);
        conv(8'h00);
        chk(32'(irq), 32'h0);
        apb(1'b0, ACPC_OFF_RESH, 32'h0);
        chk(rd, 32'hA9);
        apb(1'b1, ACPC_OFF_IMASK, 32'h1);
        apb(1'b0, ACPC_OFF_RESL, 32'h0);
        chk(rd, 32'h40);
        chk(32'(irq), 32'h1);
        apb(1'b1, ACPC_OFF_ISTAT, 32'h1);
        // disable in mid-conversion: no flag even when the core answers late
        dly <= 8'hC8;
        apb(1'b1, ACPC_OFF_CTRL0, 32'h0F);
        apb(1'b1, ACPC_OFF_CTRL0, 32'h0C);
        apb(1'b0, ACPC_OFF_CTRL0, 32'h0);
        chk(rd, 32'h0C);
        repeat (220) @(posedge MCLK);
        apb(1'b0, ACPC_OFF_ISTAT, 32'h0);
        chk(rd, 32'h0);
        // reset in mid-conversion with the strap high; enable first so start takes
        apb(1'b1, ACPC_OFF_CTRL0, 32'h0D);
        apb(1'b1, ACPC_OFF_CTRL0, 32'h0F);
        strap <= 1'b1;
        reset_dut();
        apb(1'b0, ACPC_OFF_CTRL0, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, ACPC_OFF_CTRL1, 32'h0);
        chk(rd, 32'h0);
        chk(32'(acfg), 32'h1FFF);
        print_verdict();
    end
endmodule // tb_top
`default_nettype wire
